// File: hdl/vic_controller.sv
/*
 * Vectored interrupt controller with the acknowledge sequence:
 * priority encoding, enable flags, return-address pushes, vector
 * fetch and program counter load, plus the nonmaskable entry.
 * Assumes requests and core strobes on mclk, nmiPin from a pin, and a
 * byte memory port that answers with memReady.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vic_regs.svh"

module vic_controller
   import vic_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Interrupt sources
   input wire vic_src_s srcReq,
   input wire logic nmiPin_n,
   // Core state and strobes
   input wire logic cpuReady,
   input wire logic enableSet,
   input wire logic enableClear,
   input wire logic pageWrite,
   input wire logic [7:0] pageData,
   input wire logic long_address_flag,
   input wire logic mixed_mode_flag,
   input wire logic [7:0] memory_base_byte,
   input wire logic [15:0] short_stack_pointer,
   input wire logic [23:0] long_stack_pointer,
   input wire logic [23:0] returnPc,
   // Status toward the core
   output logic intRequest,
   output logic [7:0] vector_low_bus,
   output logic [7:0] intPage,
   output logic int_enable_flag_a,
   output logic int_enable_flag_b,
   output logic busy,
   // Memory byte port
   output vic_mem_s memOut,
   input wire logic [7:0] memRdata,
   input wire logic memReady,
   // Results of the sequence, one-cycle strobe
   output logic seqDone,
   output logic [23:0] pcNew,
   output logic [23:0] stackNew,
   output logic stackIsShort,
   output logic setLongFlag,
   output logic [15:0] isrAddr
);

   // Slot of a code in the encoder table
   function automatic logic [`VIC_SLOT_W-1:0] slotOf(input logic [7:0] v);
      return v[`VIC_SLOT_W:1];
   endfunction

   // One byte down; the short stack wraps inside its base bank
   function automatic logic [23:0] stackDec(input logic [23:0] sp,
                                            input logic isShort);
      return isShort ? {sp[23:16], sp[15:0] - 16'(`VIC_ADDR_ONE)} :
                       sp - `VIC_ADDR_ONE;
   endfunction

   logic [`VIC_SLOTS-1:0] slotReq;
   logic anyReq;
   logic [7:0] encVector;
   logic nmiSync1_reg, nmiSync2_reg, nmiPrev_reg, nmiPend_reg;
   logic nmiFall;
   logic [7:0] page_reg;
   logic flagA_reg, flagB_reg;
   vic_state_e state_reg;
   logic take, takeNmi, beat;
   logic [7:0] vecLatch_reg;
   logic isNmi_reg;
   logic [31:0] pushBuf_reg;
   logic [2:0] pushCnt_reg;
   logic [23:0] sp_reg;
   logic short_reg, mixedToLong_reg;
   logic [7:0] upper_reg;
   logic [7:0] loByte_reg;
   logic [23:0] fetchAddr;
   vic_mem_s mem_next;
   logic done_reg;
   logic [23:0] pc_reg;

   // Slot map: unmapped slots stay tied low
   always_comb begin
      slotReq = '0;
      slotReq[slotOf(`VIC_VEC_FLASH)] = srcReq.flash;
      for (int i = 0; i < 6; i++) begin
         slotReq[slotOf(`VIC_VEC_PRT0) + i] = srcReq.programmable_reload_timer[i];
      end
      slotReq[slotOf(`VIC_VEC_RTC)] = srcReq.rtc;
      slotReq[slotOf(`VIC_VEC_UART0)] = srcReq.uart[0];
      slotReq[slotOf(`VIC_VEC_UART0) + 1] = srcReq.uart[1];
      slotReq[slotOf(`VIC_VEC_I2C)] = srcReq.i2c;
      slotReq[slotOf(`VIC_VEC_SPI)] = srcReq.spi;
      for (int i = 0; i < 8; i++) begin
         slotReq[slotOf(`VIC_VEC_PORTB0) + i] = srcReq.portB[i];
         slotReq[slotOf(`VIC_VEC_PORTC0) + i] = srcReq.portC[i];
         slotReq[slotOf(`VIC_VEC_PORTD0) + i] = srcReq.portD[i];
      end
   end

   vic_prio_encoder encoder (
      .mclk(mclk),
      .rstn(rstn),
      .slotReq(slotReq),
      .anyReq(anyReq),
      .vector(encVector)
   );

   assign intRequest = anyReq;
   assign vector_low_bus = encVector;

   // Pin synchroniser; edge detect reads the second stage and its delayed copy
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         nmiSync1_reg <= 1'b1;
         nmiSync2_reg <= 1'b1;
         nmiPrev_reg <= 1'b1;
      end else begin
         nmiSync1_reg <= nmiPin_n;
         nmiSync2_reg <= nmiSync1_reg;
         nmiPrev_reg <= nmiSync2_reg;
      end
   end

   assign nmiFall = nmiPrev_reg & ~nmiSync2_reg;

   // New edge wins over acceptance of the previous one
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         nmiPend_reg <= 1'b0;
      end else if (nmiFall) begin
         nmiPend_reg <= 1'b1;
      end else if (takeNmi) begin
         nmiPend_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         page_reg <= `VIC_PAGE_RST;
      end else if (pageWrite) begin
         page_reg <= pageData;
      end
   end

   assign intPage = page_reg;

   // Nonmaskable ignores the flags and is served before maskables
   assign take = (state_reg == ST_IDLE) && cpuReady &&
                 (nmiPend_reg || (anyReq && flagA_reg));
   assign takeNmi = take && nmiPend_reg;

   // Maskable acceptance clears both flags and nonmaskable acceptance flag A only, over any concurrent software set
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         flagA_reg <= 1'b0;
         flagB_reg <= 1'b0;
      end else if (takeNmi) begin
         flagA_reg <= 1'b0;
      end else if (take) begin
         flagA_reg <= 1'b0;
         flagB_reg <= 1'b0;
      end else if (enableSet) begin
         flagA_reg <= 1'b1;
         flagB_reg <= 1'b1;
      end else if (enableClear) begin
         flagA_reg <= 1'b0;
         flagB_reg <= 1'b0;
      end
   end

   assign int_enable_flag_a = flagA_reg;
   assign int_enable_flag_b = flagB_reg;

   assign beat = memOut.req && memReady;

   // Sequencer
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
      end else begin
         unique case (state_reg)
            ST_IDLE: if (take) state_reg <= ST_PUSH;
            ST_PUSH: begin
               if (beat && pushCnt_reg == `VIC_CNT_ONE) begin
                  state_reg <= isNmi_reg ? ST_LOAD : ST_FETCH_LO;
               end
            end
            ST_FETCH_LO: if (beat) state_reg <= ST_FETCH_HI;
            ST_FETCH_HI: if (beat) state_reg <= ST_LOAD;
            ST_LOAD: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Push plan captured at acceptance; bytes leave from the top
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         vecLatch_reg <= `VIC_BYTE_ZERO;
         isNmi_reg <= 1'b0;
         pushBuf_reg <= '0;
         pushCnt_reg <= `VIC_CNT_ZERO;
         sp_reg <= '0;
         short_reg <= 1'b0;
         mixedToLong_reg <= 1'b0;
         upper_reg <= `VIC_BYTE_ZERO;
      end else if (take) begin
         vecLatch_reg <= encVector;
         isNmi_reg <= nmiPend_reg;
         short_reg <= !long_address_flag && !mixed_mode_flag;
         mixedToLong_reg <= !long_address_flag && mixed_mode_flag;
         unique case ({long_address_flag, mixed_mode_flag})
            2'b00: begin
               pushBuf_reg <= {returnPc[15:0], 16'h0000};
               pushCnt_reg <= `VIC_PUSH_COMPAT;
               sp_reg <= {memory_base_byte, short_stack_pointer};
               upper_reg <= memory_base_byte;
            end
            2'b10: begin
               pushBuf_reg <= {returnPc, 8'h00};
               pushCnt_reg <= `VIC_PUSH_LONG;
               sp_reg <= long_stack_pointer;
               upper_reg <= `VIC_BYTE_ZERO;
            end
            2'b01: begin
               pushBuf_reg <= {returnPc[15:0], `VIC_MARK_COMPAT,
                               8'h00};
               pushCnt_reg <= `VIC_PUSH_COMPAT + `VIC_PUSH_MARK;
               sp_reg <= long_stack_pointer;
               upper_reg <= `VIC_BYTE_ZERO;
            end
            2'b11: begin
               pushBuf_reg <= {returnPc, `VIC_MARK_LONG};
               pushCnt_reg <= `VIC_PUSH_LONG + `VIC_PUSH_MARK;
               sp_reg <= long_stack_pointer;
               upper_reg <= `VIC_BYTE_ZERO;
            end
         endcase
      end else if (state_reg == ST_PUSH && beat) begin
         pushBuf_reg <= {pushBuf_reg[23:0], 8'h00};
         pushCnt_reg <= pushCnt_reg - `VIC_CNT_ONE;
         sp_reg <= stackDec(sp_reg, short_reg);
      end
   end

   // Vector entry {upper, page, vector}, low byte first
   assign fetchAddr = {upper_reg, page_reg, vecLatch_reg};

   // Short stack wraps inside the base bank
   always_comb begin
      mem_next = '0;
      unique case (state_reg)
         ST_PUSH: begin
            mem_next.req = 1'b1;
            mem_next.we = 1'b1;
            mem_next.addr = stackDec(sp_reg, short_reg);
            mem_next.wdata = pushBuf_reg[31:24];
         end
         ST_FETCH_LO: begin
            mem_next.req = 1'b1;
            mem_next.addr = fetchAddr;
         end
         ST_FETCH_HI: begin
            mem_next.req = 1'b1;
            mem_next.addr = fetchAddr + `VIC_ADDR_ONE;
         end
         default: mem_next = '0;
      endcase
   end

   assign memOut = mem_next;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         loByte_reg <= `VIC_BYTE_ZERO;
         pc_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (state_reg == ST_FETCH_LO && beat) begin
            loByte_reg <= memRdata;
         end
         if (state_reg == ST_FETCH_HI && beat) begin
            pc_reg <= {upper_reg, memRdata, loByte_reg};
         end
         if (state_reg == ST_PUSH && beat && isNmi_reg &&
             pushCnt_reg == `VIC_CNT_ONE) begin
            pc_reg <= {upper_reg, `VIC_NMI_ADDR};
         end
         if (state_reg == ST_LOAD) begin
            done_reg <= 1'b1;
         end
      end
   end

   assign busy = state_reg != ST_IDLE;
   assign seqDone = done_reg;
   assign pcNew = pc_reg;
   assign stackNew = sp_reg;
   assign stackIsShort = short_reg;
   assign setLongFlag = done_reg && mixedToLong_reg;
   assign isrAddr = {page_reg, vecLatch_reg};

endmodule // vic_controller

`default_nettype wire

// File: include/vic_regs.svh
/*
 * Constants of the vectored interrupt controller: low vector codes,
 * reset values and fixed addresses.
 * Assumes inclusion by bare name from the design and bench files.
 */
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH

// Low vector codes of the maskable sources
`define VIC_VEC_FLASH 8'h08
`define VIC_VEC_PRT0 8'h0A
`define VIC_VEC_RTC 8'h16
`define VIC_VEC_UART0 8'h18
`define VIC_VEC_I2C 8'h1C
`define VIC_VEC_SPI 8'h1E
`define VIC_VEC_PORTB0 8'h30
`define VIC_VEC_PORTC0 8'h40
`define VIC_VEC_PORTD0 8'h50

// Slot table: one slot per even code from 00h to 5Eh
`define VIC_SLOTS 48
`define VIC_SLOT_W 6

// Reset values and fixed bytes
`define VIC_PAGE_RST 8'h00
`define VIC_BYTE_ZERO 8'h00
`define VIC_MARK_COMPAT 8'h00
`define VIC_MARK_LONG 8'h01
`define VIC_NMI_ADDR 16'h0066
`define VIC_ADDR_ONE 24'h000001
`define VIC_CNT_ZERO 3'h0
`define VIC_CNT_ONE 3'h1
`define VIC_PUSH_COMPAT 3'h2
`define VIC_PUSH_LONG 3'h3
`define VIC_PUSH_MARK 3'h1

`endif

// File: include/vic_pkg.sv
/*
 * Types of the vectored interrupt controller.
 * Assumes vic_regs.svh for the numeric constants.
 */
package vic_pkg;

   // Requests from on-chip peripherals and GPIO ports
   typedef struct packed {
      logic flash;
      logic [5:0] programmable_reload_timer;
      logic rtc;
      logic [1:0] uart;
      logic i2c;
      logic spi;
      logic [7:0] portB;
      logic [7:0] portC;
      logic [7:0] portD;
   } vic_src_s;

   // One byte access toward memory
   typedef struct packed {
      logic req;
      logic we;
      logic [23:0] addr;
      logic [7:0] wdata;
   } vic_mem_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PUSH = 3'b001,
      ST_FETCH_LO = 3'b010,
      ST_FETCH_HI = 3'b011,
      ST_LOAD = 3'b100
   } vic_state_e;

endpackage

// File: hdl/vic_prio_encoder.sv
/*
 * Registered fixed-priority encoder over the vector slot table.
 * Assumes slot requests come from logic on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vic_regs.svh"

module vic_prio_encoder
   import vic_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Slot requests, index is code divided by two
   input wire logic [`VIC_SLOTS-1:0] slotReq,
   // Encoded result
   output logic anyReq,
   output logic [7:0] vector
);

   logic anyReq_reg;
   logic [7:0] vector_reg;
   logic anyReq_next;
   logic [7:0] vector_next;

   // Lowest slot wins; scan downward so the lowest overwrites last
   always_comb begin
      anyReq_next = |slotReq;
      vector_next = `VIC_BYTE_ZERO;
      for (int i = `VIC_SLOTS - 1; i >= 0; i--) begin
         if (slotReq[i]) begin
            vector_next = {i[6:0], 1'b0};
         end
      end
   end

   // Re-evaluated every clock, no latching of requests
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         anyReq_reg <= 1'b0;
         vector_reg <= `VIC_BYTE_ZERO;
      end else begin
         anyReq_reg <= anyReq_next;
         vector_reg <= vector_next;
      end
   end

   assign anyReq = anyReq_reg;
   assign vector = vector_reg;

endmodule // vic_prio_encoder

`default_nettype wire

// File: tb/vic_controller_sva.sv
/* Port checker for vic_controller.
   Assumes a bind from the bench; nmiPin_n high in maskable runs. */
`timescale 1ns/1ps
`default_nettype none
module vic_controller_sva
   import vic_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Inputs
   input wire vic_src_s srcReq,
   input wire logic nmiPin_n,
   input wire logic cpuReady,
   input wire logic long_address_flag,
   input wire logic mixed_mode_flag,
   input wire logic [7:0] memory_base_byte,
   // Outputs
   input wire logic intRequest,
   input wire logic [7:0] vector_low_bus,
   input wire logic [7:0] intPage,
   input wire logic int_enable_flag_a,
   input wire logic int_enable_flag_b,
   input wire logic busy,
   input wire vic_mem_s memOut,
   input wire logic seqDone,
   input wire logic setLongFlag,
   input wire logic [15:0] isrAddr
);
   logic [7:0] expCode;
   logic anySrc;
   logic live_reg;

   // Own encoder, kept apart from the design's
   function automatic logic [7:0] low_code(input vic_src_s s);
      logic [47:0] slot;
      slot = '0;
      slot[15:4] = {s.spi, s.i2c, s.uart, s.rtc, s.programmable_reload_timer, s.flash};
      slot[47:24] = {s.portD, s.portC, s.portB};
      low_code = 8'h00;
      for (int i = 47; i >= 0; i--)
         if (slot[i])
            low_code = 8'(2 * i);
   endfunction

   assign expCode = low_code(srcReq);
   assign anySrc = |srcReq;

   // First edge after release still shows reset values
   always_ff @(posedge mclk or negedge rstn)
      if (!rstn)
         live_reg <= 1'b0;
      else
         live_reg <= 1'b1;

   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   chk_req_any: assert property (
      live_reg |-> intRequest == $past(anySrc))
      else $error("request line wrong");
   chk_vec_code: assert property (
      live_reg |-> vector_low_bus == $past(expCode))
      else $error("vector bus wrong");
   chk_accept_clear: assert property (
      !busy && cpuReady && intRequest && int_enable_flag_a && nmiPin_n
      |=> busy && !int_enable_flag_a && !int_enable_flag_b)
      else $error("acceptance did not start or clear flags");
   chk_isr_page: assert property (
      seqDone |-> isrAddr[15:8] == intPage)
      else $error("service address page wrong");
   chk_long_set: assert property (
      setLongFlag |-> seqDone && mixed_mode_flag && !long_address_flag)
      else $error("long flag set in wrong mode");
   chk_base_bank: assert property (
      memOut.req && !long_address_flag && !mixed_mode_flag
      |-> memOut.addr[23:16] == memory_base_byte)
      else $error("access outside base bank");
   chk_zero_bank: assert property (
      memOut.req && !memOut.we && (long_address_flag || mixed_mode_flag)
      |-> memOut.addr[23:16] == 8'h00)
      else $error("fetch outside bank zero");
   chk_page_reset: assert property (disable iff (1'b0)
      !rstn |-> intPage == 8'h00 && !int_enable_flag_a)
      else $error("page or flag not cleared in reset");
endmodule // vic_controller_sva
`default_nettype wire

// File: tb/vic_mem_model.sv
/* Byte memory on the controller's memory port with selectable stall.
   Assumes one access at a time, held until memReady. */
`timescale 1ns/1ps
`default_nettype none
module vic_mem_model
   import vic_pkg::*;
(
   // Clock, reset, stall cycles per beat
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [1:0] stall,
   // Memory port
   input wire vic_mem_s memOut,
   output logic [7:0] memRdata,
   output logic memReady
);
   logic [7:0] store [bit [23:0]];
   logic [1:0] waitCnt_reg;
   logic [7:0] lastData_reg = 8'h5A;

   function automatic logic [7:0] peek(input logic [23:0] a);
      return store.exists(a) ? store[a] : 8'hEE;
   endfunction

   task automatic poke(input logic [23:0] a, input logic [7:0] d);
      store[a] = d;
   endtask

   assign memReady = memOut.req && waitCnt_reg == stall;
   // Off a beat the data keeps changing, so a stray sample shows
   always_comb
      memRdata = memReady ? peek(memOut.addr) : ~lastData_reg;

   always_ff @(posedge mclk or negedge rstn)
      if (!rstn)
         waitCnt_reg <= 2'h0;
      else if (memReady)
         waitCnt_reg <= 2'h0;
      else if (memOut.req)
         waitCnt_reg <= waitCnt_reg + 2'h1;

   always @(posedge mclk) begin
      lastData_reg <= memRdata;
      if (memReady && memOut.we)
         store[memOut.addr] = memOut.wdata;
   end
endmodule // vic_mem_model
`default_nettype wire

// File: tb/testbench.sv
/* Self-checking bench for vic_controller with a byte memory model.
   Assumes package, constants header and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "vic_regs.svh"
module testbench
   import vic_pkg::*;
;
   localparam logic [7:0] PAGE = 8'h5C;
   logic mclk = 1'b0, rstn = 1'b1, nmiPin_n = 1'b1, cpuReady = 1'b0;
   logic enableSet = 1'b0, enableClear = 1'b0, pageWrite = 1'b0;
   logic long_address_flag = 1'b0, mixed_mode_flag = 1'b0;
   logic [7:0] pageData = 8'h00, memory_base_byte = 8'h3C;
   logic [15:0] short_stack_pointer = 16'h8000;
   logic [23:0] long_stack_pointer = 24'h123456, returnPc = 24'h000000;
   logic [1:0] stall = 2'h0;
   vic_src_s srcReq = '0;
   vic_mem_s memOut;
   logic [7:0] memRdata, vector_low_bus, intPage;
   logic memReady, intRequest, int_enable_flag_a, int_enable_flag_b;
   logic busy, seqDone, stackIsShort, setLongFlag;
   logic [23:0] pcNew, stackNew;
   logic [15:0] isrAddr;
   logic [1:0] ief;
   int n_mismatch = 0;
   int compares = 0;

   assign ief = {int_enable_flag_a, int_enable_flag_b};

   always #5 mclk = ~mclk;

   vic_controller dut (.*);
   vic_mem_model mem (.*);

   // Bit b of the packed source word to its low vector code
   function automatic logic [7:0] code_of(input int b);
      if (b == 35)
         return `VIC_VEC_FLASH;
      if (b >= 29)
         return 8'(`VIC_VEC_PRT0 + 2 * (b - 29));
      if (b == 28)
         return `VIC_VEC_RTC;
      if (b >= 26)
         return 8'(`VIC_VEC_UART0 + 2 * (b - 26));
      if (b >= 24)
         return (b == 25) ? `VIC_VEC_I2C : `VIC_VEC_SPI;
      return 8'(8'h30 + 16 * (2 - b / 8) + 2 * (b % 8));
   endfunction

   task automatic check(input string what, input logic [23:0] exp,
      input logic [23:0] got);
      compares++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask

   task automatic test_done();
      if (n_mismatch == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Bounded wait for the completion strobe
   task automatic accept();
      int k;
      k = 0;
      cpuReady <= 1'b1;
      do begin
         @(posedge mclk);
         #1;
         k++;
      end while (seqDone !== 1'b1 && k < 100);
      check("done", 24'h1, 24'(seqDone));
   endtask

   initial begin
      #60us;
      n_mismatch++;
      test_done();
   end

   initial begin
      logic [35:0] mask;
      logic [23:0] sp, base;
      logic [7:0] got8;
      int n;
      // Falling edge at time zero so every flop takes its reset value
      rstn <= 1'b0;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      #1;
      check("page", 24'(`VIC_PAGE_RST), 24'(intPage));
      for (int b = 35; b >= 0; b--) begin
         mask = '0;
         for (int c = 0; c < 36; c++)
            mask[c] = code_of(c) >= code_of(b);
         @(posedge mclk);
         srcReq <= vic_src_s'(36'h1 << b);
         repeat (2) @(posedge mclk);
         #1;
         check("vec", 24'(code_of(b)), 24'(vector_low_bus));
         check("req", 24'h1, 24'(intRequest));
         @(posedge mclk);
         srcReq <= vic_src_s'(mask);
         repeat (2) @(posedge mclk);
         #1;
         check("prio", 24'(code_of(b)), 24'(vector_low_bus));
      end
      @(posedge mclk);
      srcReq <= '0;
      pageWrite <= 1'b1;
      pageData <= PAGE;
      @(posedge mclk);
      pageWrite <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      check("idle", 24'h0, 24'({intRequest, vector_low_bus}));
      check("page", 24'(PAGE), 24'(intPage));
      for (int m = 0; m < 4; m++) begin
         base = (m == 0) ? {memory_base_byte, 16'h0000} : 24'h000000;
         n = m[0] ? 3 : 2;
         sp = (m == 0) ? {memory_base_byte, short_stack_pointer}
            : long_stack_pointer;
         mem.poke(base | {8'h00, PAGE, 8'h1E}, 8'h40 + 8'(m));
         mem.poke(base | {8'h00, PAGE, 8'h1F}, 8'h12);
         @(posedge mclk);
         long_address_flag <= m[0];
         mixed_mode_flag <= m[1];
         returnPc <= 24'hABCDE0 + 24'(m);
         stall <= 2'(m);
         enableSet <= 1'b1;
         // Source holds until the sequence ends
         srcReq <= vic_src_s'(36'h1 << 24);
         @(posedge mclk);
         enableSet <= 1'b0;
         accept();
         check("pc", base | 24'h1240 + 24'(m), pcNew);
         check("sp", sp - 24'(n) - 24'(m[1]), stackNew);
         check("short", 24'(m == 0), 24'(stackIsShort));
         check("setlong", 24'(m == 2), 24'(setLongFlag));
         check("ief", 24'h0, 24'(ief));
         check("isr", {8'h00, PAGE, 8'h1E}, 24'(isrAddr));
         for (int k = 1; k <= n; k++) begin
            got8 = mem.peek(sp - 24'(k));
            check("push", 24'(returnPc[8*(n-k)+:8]), 24'(got8));
         end
         if (m[1]) begin
            got8 = mem.peek(sp - 24'(n + 1));
            check("mark", 24'(m[0]), 24'(got8));
         end
         @(posedge mclk);
         cpuReady <= 1'b0;
         srcReq <= '0;
      end
      @(posedge mclk);
      long_address_flag <= 1'b1;
      mixed_mode_flag <= 1'b0;
      enableSet <= 1'b1;
      srcReq <= vic_src_s'(36'h1 << 24);
      nmiPin_n <= 1'b0;
      @(posedge mclk);
      enableSet <= 1'b0;
      repeat (4) @(posedge mclk);
      accept();
      check("nmi", 24'(`VIC_NMI_ADDR), pcNew);
      check("nmi ief", 24'h1, 24'(ief));
      @(posedge mclk);
      nmiPin_n <= 1'b1;
      repeat (8) @(posedge mclk);
      #1;
      // Pending source while enable is off stays waiting
      check("masked", 24'h2, 24'({intRequest, busy}));
      @(posedge mclk);
      enableClear <= 1'b1;
      @(posedge mclk);
      enableClear <= 1'b0;
      #1;
      check("clear", 24'h0, 24'(ief));
      test_done();
   end
endmodule // testbench

bind vic_controller vic_controller_sva chk (
   .mclk(mclk),
   .rstn(rstn),
   .srcReq(srcReq),
   .nmiPin_n(nmiPin_n),
   .cpuReady(cpuReady),
   .long_address_flag(long_address_flag),
   .mixed_mode_flag(mixed_mode_flag),
   .memory_base_byte(memory_base_byte),
   .intRequest(intRequest),
   .vector_low_bus(vector_low_bus),
   .intPage(intPage),
   .int_enable_flag_a(int_enable_flag_a),
   .int_enable_flag_b(int_enable_flag_b),
   .busy(busy),
   .memOut(memOut),
   .seqDone(seqDone),
   .setLongFlag(setLongFlag),
   .isrAddr(isrAddr)
);
`default_nettype wire
